// [shared/spp_pkg.sv]
package spp_pkg;
    // Entry key pattern
    localparam logic [31:0] SPP_KEY = 32'h4D43_4851;
    // Control codes
    localparam logic [3:0] SPP_CODE_EXEC = 4'h0;
    localparam logic [3:0] SPP_CODE_READ = 4'h1;
    // Word sizes and cycle counts in serial clocks
    localparam int SPP_KEY_BITS = 32;
    localparam int SPP_INSTR_BITS = 24;
    localparam int SPP_CODE_BITS = 4;
    localparam int SPP_FIRST_EXTRA = 5;
    localparam int SPP_EXEC_CLKS = 4;
    localparam int SPP_READ_IDLE = 8;
    localparam int SPP_READ_BITS = 16;
    // System clock and timing figures
    localparam int SPP_SYS_NS = 25;
    localparam int SPP_P7_NS = 50;
    localparam int SPP_P7_CYC = (SPP_P7_NS + SPP_SYS_NS - 1) / SPP_SYS_NS;
    localparam int SPP_P18_NS = 50;
    localparam int SPP_P18_CYC = (SPP_P18_NS + SPP_SYS_NS - 1) / SPP_SYS_NS;
    localparam int SPP_SCK_MAX_KHZ = 5000;
    localparam int SPP_SCK_HALF = (1_000_000 / SPP_SCK_MAX_KHZ / 2 + SPP_SYS_NS - 1) / SPP_SYS_NS;
    // Device state
    typedef enum logic [6:0] {
        SPP_OFF = 7'b000_0001,
        SPP_KEYIN = 7'b000_0010,
        SPP_WAIT = 7'b000_0100,
        SPP_CODE = 7'b000_1000,
        SPP_INSTR = 7'b001_0000,
        SPP_IDLE8 = 7'b010_0000,
        SPP_OUT = 7'b100_0000
    } spp_state_t;
endpackage : spp_pkg

// [shared/spp_if.sv]
`timescale 1ns/1ps
interface spp_if;
    logic prog_serial_clock_pin; // Driven by programmer only
    logic master_clear_pin; // Driven by programmer only
    logic data_from_prog; // Programmer data out
    logic data_oe_prog; // Programmer driving data
    logic data_from_dev; // Device data out
    logic data_oe_dev; // Device driving data
    logic prog_serial_data_pin; // Resolved wire level
    assign prog_serial_data_pin = data_oe_dev ? data_from_dev : (data_oe_prog ? data_from_prog : 1'b1);
    modport device (input prog_serial_clock_pin, input master_clear_pin, input prog_serial_data_pin,
                    output data_from_dev, output data_oe_dev);
    modport host (output prog_serial_clock_pin, output master_clear_pin, input prog_serial_data_pin,
                  output data_from_prog, output data_oe_prog);
endinterface : spp_if

// [rtl/spp_device.sv]
`timescale 1ns/1ps
module spp_device
    import spp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    spp_if.device link,
    input wire logic [15:0] visibility_out_reg, // Word offered for readout
    output logic mode_active, // Program/verify mode entered
    output logic pins_hiz, // Unused pins to be released
    output logic cpu_clk_en, // CPU execution clock enable
    output logic [23:0] instr_reg, // Instruction register
    output logic exec_pulse, // Instruction loaded for execution
    output logic [1:0] exec_phase // Execution clock in progress
);
    ////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops each
    logic [1:0] sck_s, clr_s, dat_s;
    logic sck_q; // Previous synced clock
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sck_s <= 2'b00;
            clr_s <= 2'b00;
            dat_s <= 2'b11;
            sck_q <= 1'b0;
        end else begin
            sck_s <= {sck_s[0], link.prog_serial_clock_pin};
            clr_s <= {clr_s[0], link.master_clear_pin};
            dat_s <= {dat_s[0], link.prog_serial_data_pin};
            sck_q <= sck_s[1];
        end
    end
    logic rise; // Serial clock rising edge
    assign rise = sck_s[1] & ~sck_q;
    logic clr;
    logic din;
    assign clr = clr_s[1];
    assign din = dat_s[1];

    ////////////////////////////////////////////////////////////
    // State machine and shift logic
    spp_state_t state;
    logic [31:0] shreg; // Shared input shifter
    logic [5:0] cnt; // Bit counter
    logic [15:0] outreg; // Readout shifter
    logic [7:0] wait_cnt; // P7 holdoff counter
    logic [2:0] exec_cnt; // Execution clocks left
    logic clr_q; // Clear level one cycle late
    logic first; // Forced first command pending
    // Serial clock is the CPU clock for four rises after each instruction load
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cpu_clk_en <= 1'b0;
        end else begin
            cpu_clk_en <= rise && (exec_cnt != 3'd0);
        end
    end
    // Main sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= SPP_OFF;
            shreg <= '0;
            cnt <= '0;
            outreg <= '0;
            wait_cnt <= '0;
            clr_q <= 1'b0;
            mode_active <= 1'b0;
            instr_reg <= '0;
            exec_pulse <= 1'b0;
            link.data_from_dev <= 1'b0;
            link.data_oe_dev <= 1'b0;
        end else begin
            clr_q <= clr;
            exec_pulse <= 1'b0;
            if (state != SPP_OFF && state != SPP_KEYIN && state != SPP_WAIT && !clr) begin
                // Clear dropped: leave mode
                state <= SPP_OFF;
                mode_active <= 1'b0;
                link.data_oe_dev <= 1'b0;
            end else begin
                unique case (state)
                    SPP_OFF: begin
                        // High-then-low pulse on clear arms key capture
                        if (clr_q && !clr) begin
                            state <= SPP_KEYIN;
                            cnt <= '0;
                        end
                    end
                    SPP_KEYIN: begin
                        if (rise) begin
                            shreg <= {shreg[30:0], din};
                            cnt <= cnt + 6'd1;
                        end
                        if (clr) begin
                            // Exact key only; else stay outside
                            if (cnt == 6'(SPP_KEY_BITS) && shreg == SPP_KEY) begin
                                state <= SPP_WAIT;
                                wait_cnt <= '0;
                            end else begin
                                state <= SPP_OFF;
                            end
                        end
                    end
                    SPP_WAIT: begin
                        // Data ignored until holdoff ends
                        if (!clr) begin
                            state <= SPP_OFF;
                        end else if (wait_cnt == 8'(SPP_P7_CYC)) begin
                            state <= SPP_CODE;
                            mode_active <= 1'b1;
                            cnt <= 6'(SPP_CODE_BITS + SPP_FIRST_EXTRA);
                            shreg <= '0;
                        end else begin
                            wait_cnt <= wait_cnt + 8'd1;
                        end
                    end
                    SPP_CODE: begin
                        // Code shifts LSB first while previous executes
                        if (rise) begin
                            shreg <= {din, shreg[31:1]};
                            if (cnt == 6'd1) begin
                                cnt <= 6'(SPP_INSTR_BITS);
                                // First nine-bit code forced to execute
                                if (first) begin
                                    state <= SPP_INSTR;
                                end else if ({din, shreg[31:29]} == SPP_CODE_EXEC) begin
                                    state <= SPP_INSTR;
                                end else if ({din, shreg[31:29]} == SPP_CODE_READ) begin
                                    state <= SPP_IDLE8;
                                    cnt <= 6'(SPP_READ_IDLE);
                                end else begin
                                    cnt <= 6'(SPP_CODE_BITS);
                                end
                            end else begin
                                cnt <= cnt - 6'd1;
                            end
                        end
                    end
                    SPP_INSTR: begin
                        // CPU suspended while instruction shifts in
                        if (rise) begin
                            shreg <= {din, shreg[31:1]};
                            if (cnt == 6'd1) begin
                                instr_reg <= {din, shreg[31:9]};
                                exec_pulse <= 1'b1;
                                state <= SPP_CODE;
                                cnt <= 6'(SPP_CODE_BITS);
                            end else begin
                                cnt <= cnt - 6'd1;
                            end
                        end
                    end
                    SPP_IDLE8: begin
                        // Pin stays input while idle clocks pass
                        if (rise) begin
                            if (cnt == 6'd1) begin
                                state <= SPP_OUT;
                                cnt <= 6'(SPP_READ_BITS);
                                outreg <= {1'b0, visibility_out_reg[15:1]};
                                link.data_from_dev <= visibility_out_reg[0];
                                link.data_oe_dev <= 1'b1;
                            end else begin
                                cnt <= cnt - 6'd1;
                            end
                        end
                    end
                    SPP_OUT: begin
                        // Output advances on each rising edge but the last, which releases the pin
                        if (rise) begin
                            if (cnt == 6'd1) begin
                                link.data_oe_dev <= 1'b0;
                                state <= SPP_CODE;
                                cnt <= 6'(SPP_CODE_BITS);
                            end else begin
                                link.data_from_dev <= outreg[0];
                                outreg <= {1'b0, outreg[15:1]};
                                cnt <= cnt - 6'd1;
                            end
                        end
                    end
                    default: state <= SPP_OFF;
                endcase
            end
        end
    end
    // First command after entry is forced
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            first <= 1'b0;
        end else if (state == SPP_WAIT) begin
            first <= 1'b1;
        end else if (state == SPP_INSTR) begin
            first <= 1'b0;
        end
    end
    // Execution window of four serial clocks
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            exec_cnt <= '0;
        end else if (exec_pulse) begin
            exec_cnt <= 3'(SPP_EXEC_CLKS);
        end else if (rise && exec_cnt != 3'd0) begin
            exec_cnt <= exec_cnt - 3'd1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            exec_phase <= '0;
            pins_hiz <= 1'b0;
        end else begin
            exec_phase <= 2'(3'(SPP_EXEC_CLKS) - exec_cnt);
            pins_hiz <= mode_active;
        end
    end
endmodule : spp_device

// [rtl/spp_host.sv]
`timescale 1ns/1ps
module spp_host
    import spp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    spp_if.host link,
    input wire logic enter_req, // Pulse: run entry sequence
    input wire logic cmd_req, // Pulse: send one command
    input wire logic [3:0] cmd_code, // Control code to send
    input wire logic [23:0] cmd_instr, // Instruction for execute
    output logic busy, // Sequence in progress
    output logic [15:0] read_data, // Last readout word
    output logic read_valid // Pulse: readout word ready
);
    // Clock, clear and data driving
    typedef enum logic [5:0] {
        SPH_IDLE = 6'b00_0001, SPH_PULSE = 6'b00_0010, SPH_GAP = 6'b00_0100,
        SPH_SHIFT = 6'b00_1000, SPH_HOLD = 6'b01_0000, SPH_RD = 6'b10_0000
    } spp_host_state_t;
    spp_host_state_t st;
    logic [1:0] din_s; // Data pin synchroniser
    logic [7:0] div; // Period divider, rise at half count, keeps clock under 5 MHz
    logic [63:0] sh; // Outgoing bits
    logic [6:0] n; // Bits remaining
    logic [4:0] rd_n; // Read clocks remaining
    logic entering; // Entry in progress
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            din_s <= 2'b11;
        end else begin
            din_s <= {din_s[0], link.prog_serial_data_pin};
        end
    end
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st <= SPH_IDLE; div <= '0; sh <= '0; n <= '0; rd_n <= '0;
            entering <= 1'b0; busy <= 1'b0; read_data <= '0; read_valid <= 1'b0;
            link.prog_serial_clock_pin <= 1'b0;
            link.master_clear_pin <= 1'b0;
            link.data_from_prog <= 1'b0;
            link.data_oe_prog <= 1'b0;
        end else begin
            read_valid <= 1'b0;
            div <= (div == 8'(SPP_SCK_HALF * 2)) ? 8'd0 : div + 8'd1;
            unique case (st)
                SPH_IDLE: begin
                    div <= '0;
                    if (enter_req) begin
                        st <= SPH_PULSE; busy <= 1'b1; entering <= 1'b1;
                        link.master_clear_pin <= 1'b1;
                    end else if (cmd_req && link.master_clear_pin) begin
                        busy <= 1'b1; st <= SPH_SHIFT; link.data_oe_prog <= 1'b1;
                        // LSB first: code, then instruction if executing
                        sh <= {36'd0, cmd_instr, cmd_code};
                        n <= (cmd_code == SPP_CODE_EXEC) ? 7'(SPP_CODE_BITS + SPP_INSTR_BITS) : 7'(SPP_CODE_BITS);
                        rd_n <= (cmd_code == SPP_CODE_READ) ? 5'(SPP_READ_IDLE + SPP_READ_BITS) : 5'd0;
                    end
                end
                SPH_PULSE: if (div == 8'(SPP_SCK_HALF)) begin
                    link.master_clear_pin <= 1'b0; st <= SPH_GAP;
                end
                SPH_GAP: if (div == 8'(SPP_SCK_HALF - 1 + SPP_P18_CYC)) begin
                    st <= SPH_SHIFT; link.data_oe_prog <= 1'b1;
                    sh <= {32'd0, SPP_KEY}; n <= 7'd32;
                end
                SPH_SHIFT: begin
                    // Data set at clock low, taken at rise
                    if (div == 8'd0) begin
                        link.prog_serial_clock_pin <= 1'b0;
                        if (n == 7'd0) begin
                            st <= (rd_n != 5'd0) ? SPH_RD : SPH_HOLD;
                            link.data_oe_prog <= (rd_n == 5'd0);
                        end else if (entering) begin
                            link.data_from_prog <= sh[31]; sh <= {sh[62:0], 1'b0};
                        end else begin
                            link.data_from_prog <= sh[0]; sh <= {1'b0, sh[63:1]};
                        end
                    end else if (div == 8'(SPP_SCK_HALF) && n != 7'd0) begin
                        link.prog_serial_clock_pin <= 1'b1; n <= n - 7'd1;
                    end
                end
                SPH_RD: begin
                    // Eight idle clocks, then sixteen sampled
                    if (div == 8'(SPP_SCK_HALF)) begin
                        link.prog_serial_clock_pin <= 1'b1;
                        if (rd_n <= 5'(SPP_READ_BITS)) read_data <= {din_s[1], read_data[15:1]};
                        rd_n <= rd_n - 5'd1;
                    end else if (div == 8'd0) begin
                        link.prog_serial_clock_pin <= 1'b0;
                        if (rd_n == 5'd0) begin
                            st <= SPH_HOLD; read_valid <= 1'b1; link.data_oe_prog <= 1'b1;
                        end
                    end
                end
                SPH_HOLD: begin
                    // Raise clear after key; hold for mode
                    if (entering) begin
                        // Entry stays pending until the holdoff has passed
                        link.master_clear_pin <= 1'b1;
                        // First command is a nine-bit code and a zero 24-bit instruction, forced no-op
                        sh <= '0; n <= 7'(SPP_CODE_BITS + SPP_FIRST_EXTRA + SPP_INSTR_BITS);
                        rd_n <= '0;
                        if (div == 8'(SPP_P18_CYC + SPP_P7_CYC)) begin
                            st <= SPH_SHIFT;
                            entering <= 1'b0;
                        end
                    end else begin
                        st <= SPH_IDLE; busy <= 1'b0;
                    end
                end
                default: st <= SPH_IDLE;
            endcase
        end
    end
endmodule : spp_host

// [tb/spp_link_monitor.sv]
`timescale 1ns/1ps
module spp_link_monitor
(
    input wire logic sys_clk, // Main clock
    input wire logic rst_b, // Synchronous reset, low
    input wire logic prog_serial_clock_pin, // Link clock from programmer
    input wire logic master_clear_pin, // Clear and mode-hold line
    input wire logic data_from_prog, // Programmer data out
    input wire logic data_oe_prog, // Programmer drives data
    input wire logic data_from_dev, // Device data out
    input wire logic data_oe_dev, // Device drives data
    input wire logic prog_serial_data_pin, // Resolved data wire
    input wire logic mode_active, // Device mode flag
    input wire logic pins_hiz, // Unused pins released
    input wire logic exec_pulse // Instruction loaded
);
    default clocking mon_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    logic sck_q; // Link clock one cycle late
    logic [3:0] rise_age; // Cycles since last link clock rise
    // Delay line for edge finding
    always_ff @(posedge sys_clk) begin
        sck_q <= prog_serial_clock_pin;
    end
    // Saturating age, so a fall-edge drive shows as too old
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rise_age <= 4'hF;
        end else if (prog_serial_clock_pin && !sck_q) begin
            rise_age <= 4'h0;
        end else if (rise_age != 4'hF) begin
            rise_age <= rise_age + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Readout drive holds the wire for at least sixteen system clocks from its start
    sequence oe_burst;
        data_oe_dev [*8] ##1 data_oe_dev [*8];
    endsequence
    // Gap that any two loads must leave
    sequence exec_quiet;
        !exec_pulse [*8];
    endsequence
    oe_exclusive_a: assert property (!(data_oe_dev && data_oe_prog))
        else $error("both ends drive the data wire");
    oe_in_mode_a: assert property (data_oe_dev |-> mode_active && master_clear_pin)
        else $error("device drives data outside the mode");
    hiz_in_mode_a: assert property (mode_active && $past(mode_active) |-> pins_hiz)
        else $error("unused pins not released in mode");
    entry_clear_a: assert property ($rose(mode_active) |-> master_clear_pin)
        else $error("mode entered with clear low");
    clear_exit_a: assert property ($fell(master_clear_pin) |-> ##[0:4] !mode_active)
        else $error("mode held after clear went low");
    out_hold_a: assert property ($rose(data_oe_dev) |-> oe_burst)
        else $error("readout drive cut short");
    drive_rise_a: assert property (data_oe_dev && $past(data_oe_dev) && $changed(data_from_dev)
        |-> rise_age <= 4'h6)
        else $error("data changed away from a clock rise");
    exec_space_a: assert property (exec_pulse |=> exec_quiet)
        else $error("instruction loads too close");
    exec_mode_a: assert property (exec_pulse |-> mode_active)
        else $error("instruction load outside the mode");
    out_no_exec_a: assert property (data_oe_dev |-> !exec_pulse)
        else $error("instruction load during readout");
    din_hold_a: assert property (data_oe_prog && prog_serial_clock_pin && $past(prog_serial_clock_pin)
        |-> $stable(data_from_prog))
        else $error("programmer data moved while clock high");
endmodule : spp_link_monitor

// [tb/serial_program_port_tb_top.sv]
`timescale 1ns/1ps
module serial_program_port_tb_top;
    import spp_pkg::*;
    logic sys_clk = 1'b0; // Main clock
    logic rst_b = 1'b0; // Reset, low
    logic enter_req = 1'b0; // Host entry request
    logic cmd_req = 1'b0; // Host command request
    logic [3:0] cmd_code = 4'h0; // Code to send
    logic [23:0] cmd_instr = 24'h00_0000; // Instruction to send
    logic [15:0] visibility_out_reg = 16'h0000; // Word offered for readout
    logic busy, read_valid, mode_active, pins_hiz, exec_pulse, mode_active_b, pins_hiz_b, cpu_clk_en; // Design flags
    logic [1:0] exec_phase; // Execution clock count
    logic [15:0] read_data; // Word read back
    logic [23:0] instr_reg; // Loaded instruction
    logic sck_d = 1'b0; // Link clock one cycle late
    logic [63:0] sh = '0; // Wire bits, newest on top
    logic [31:0] key_sh = '0; // Key bits seen while clear low
    logic [23:0] instrs [3] = '{24'hBA_1234, 24'h00_0000, 24'h5A_C3E1}; // Table-like, no-op, other
    logic [15:0] words [2] = '{16'hC3A5, 16'h5A0F}; // Readout words
    int mismatches = 0, samples_checked = 0, cycles = 0; // Report counters
    int n_exec = 0, n_rv = 0, oe_cnt = 0, n_cpu = 0, n0, r0, o0, c0; // Event counters
    spp_if link(); // Link between the two ends
    spp_if link_b(); // Link to a device the bench drives itself
    ////////////////////////////////////////////////////////////////
    spp_device u_spp_device (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
        .visibility_out_reg(visibility_out_reg), .mode_active(mode_active), .pins_hiz(pins_hiz),
        .cpu_clk_en(cpu_clk_en), .instr_reg(instr_reg), .exec_pulse(exec_pulse), .exec_phase(exec_phase));
    spp_host u_spp_host (.sys_clk(sys_clk), .rst_b(rst_b), .link(link), .enter_req(enter_req),
        .cmd_req(cmd_req), .cmd_code(cmd_code), .cmd_instr(cmd_instr), .busy(busy),
        .read_data(read_data), .read_valid(read_valid));
    // Second device, for bench-driven key sequences, bad and good
    spp_device u_spp_device_b (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_b),
        .visibility_out_reg(16'h0000), .mode_active(mode_active_b), .pins_hiz(pins_hiz_b),
        .cpu_clk_en(), .instr_reg(), .exec_pulse(), .exec_phase());
    spp_link_monitor u_spp_link_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
        .prog_serial_clock_pin(link.prog_serial_clock_pin), .master_clear_pin(link.master_clear_pin),
        .data_from_prog(link.data_from_prog), .data_oe_prog(link.data_oe_prog),
        .data_from_dev(link.data_from_dev), .data_oe_dev(link.data_oe_dev),
        .prog_serial_data_pin(link.prog_serial_data_pin), .mode_active(mode_active),
        .pins_hiz(pins_hiz), .exec_pulse(exec_pulse));
    ////////////////////////////////////////////////////////////////
    // Clock, 25 ns period
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Wire watcher: bits as the device sees them at each rise
    always @(posedge sys_clk) begin
        sck_d <= link.prog_serial_clock_pin;
        if (link.prog_serial_clock_pin && !sck_d) begin
            sh <= {link.prog_serial_data_pin, sh[63:1]};
            if (!link.master_clear_pin) key_sh <= {key_sh[30:0], link.prog_serial_data_pin};
        end
        if (exec_pulse === 1'b1) n_exec++;
        if (read_valid === 1'b1) n_rv++;
        if (link.data_oe_dev === 1'b1) oe_cnt++;
        if (cpu_clk_en === 1'b1) n_cpu++;
    end
    // Hang guard, well above the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One host request, then wait for busy to drop and loads to land
    task host_go(input logic is_enter, input logic [3:0] code, input logic [23:0] instr);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_code = code;
        cmd_instr = instr;
        enter_req = is_enter;
        cmd_req = !is_enter;
        @(negedge sys_clk);
        enter_req = 1'b0;
        cmd_req = 1'b0;
        repeat (2) @(negedge sys_clk);
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (8) @(negedge sys_clk);
    endtask : host_go
    // Bench as programmer on the second link; clock only within the frame
    task bang(input logic [31:0] key);
        link_b.master_clear_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        link_b.master_clear_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        link_b.data_oe_prog = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            link_b.data_from_prog = key[i];
            repeat (4) @(negedge sys_clk);
            link_b.prog_serial_clock_pin = 1'b1;
            repeat (4) @(negedge sys_clk);
            link_b.prog_serial_clock_pin = 1'b0;
        end
        link_b.data_oe_prog = 1'b0;
        link_b.master_clear_pin = 1'b1;
        repeat (20) @(negedge sys_clk);
    endtask : bang
    task end_of_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    // Main sequence: entry first, then commands in flow order
    initial begin
        link_b.prog_serial_clock_pin = 1'b0;
        link_b.master_clear_pin = 1'b0;
        link_b.data_from_prog = 1'b0;
        link_b.data_oe_prog = 1'b0;
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        bang(SPP_KEY ^ 32'h0000_0001);
        check({31'h0, mode_active_b}, 32'h0);
        bang(SPP_KEY);
        check({31'h0, mode_active_b}, 32'h1);
        check({31'h0, pins_hiz_b}, 32'h1);
        host_go(1'b1, 4'h0, 24'h00_0000);
        check({31'h0, mode_active}, 32'h1);
        check({31'h0, pins_hiz}, 32'h1);
        check(key_sh, SPP_KEY);
        // Back-to-back execute codes, table-like word, a no-op, then another word
        for (int i = 0; i < 3; i++) begin
            n0 = n_exec;
            c0 = n_cpu;
            host_go(1'b0, SPP_CODE_EXEC, instrs[i]);
            check({8'h0, instr_reg}, {8'h0, instrs[i]});
            check(32'(n_exec - n0), 32'h1);
            check({4'h0, sh[63:36]}, {4'h0, instrs[i], SPP_CODE_EXEC});
            check(32'(n_cpu - c0), 32'(SPP_EXEC_CLKS));
            check({30'h0, exec_phase}, 32'h0);
        end
        // Readout words, checked at the port and on the wire
        for (int i = 0; i < 2; i++) begin
            visibility_out_reg = words[i];
            r0 = n_rv;
            host_go(1'b0, SPP_CODE_READ, 24'h00_0000);
            check({16'h0, read_data}, {16'h0, words[i]});
            check(32'(n_rv - r0), 32'h1);
            check({16'h0, sh[63:48]}, {16'h0, words[i]});
            check({28'h0, sh[39:36]}, {28'h0, SPP_CODE_READ});
        end
        // Every reserved code: no load, no drive
        n0 = n_exec;
        o0 = oe_cnt;
        c0 = n_cpu;
        for (int c = 2; c < 16; c++) begin
            host_go(1'b0, 4'(c), 24'hFF_FFFF);
        end
        check(32'(n_exec - n0), 32'h0);
        check(32'(oe_cnt - o0), 32'h0);
        check(32'(n_cpu - c0), 32'h0);
        host_go(1'b0, SPP_CODE_EXEC, 24'h13_579B);
        check({8'h0, instr_reg}, 32'h0013_579B);
        end_of_test();
    end
endmodule : serial_program_port_tb_top
